// *** src/bpb_pkg.sv ***
package bpb_pkg;
   localparam int          CLK_MHZ        = 125;
   localparam int          REPLY_LIMIT_US = 10;
   localparam int          REPLY_LIMIT_CYC = REPLY_LIMIT_US * CLK_MHZ;
   localparam int          INIT_PULSE_US  = 10;
   localparam int          INIT_PULSE_CYC = INIT_PULSE_US * CLK_MHZ;
   localparam logic [15:0] TIMEOUT_VEC    = 16'h0004;
   localparam logic [15:0] EVENT_VEC      = 16'h0040;
   localparam logic [15:0] PWRFAIL_VEC    = 16'h0014;
   localparam logic [7:0]  PRIO_DISABLED  = 8'h80;
   localparam logic [7:0]  PRIO_ENABLED   = 8'h00;
   localparam int          PRIO_BIT       = 7;
   typedef enum logic [1:0] {
      BPB_DATI,
      BPB_DATIO,
      BPB_DATO
   } bpb_cycle_type;
endpackage : bpb_pkg

// *** src/bpb_bus_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface bpb_bus_if;
   logic [15:0] dalMaster;
   logic        dalMasterOe;
   logic [15:0] dalSlave;
   logic        dalSlaveOe;
   logic        syncN;
   logic        dinN;
   logic        doutN;
   logic        wtbtN;
   logic        replyN;
   logic        initN;
   logic        refN;
   logic        irqN;
   logic        iakoN;
   modport master (
      output dalMaster, dalMasterOe, syncN, dinN, doutN, wtbtN, initN,
             refN, iakoN,
      input  dalSlave, dalSlaveOe, replyN, irqN
   );
   modport slave (
      input  dalMaster, dalMasterOe, syncN, dinN, doutN, wtbtN, initN,
             refN, iakoN,
      output dalSlave, dalSlaveOe, replyN, irqN
   );
endinterface : bpb_bus_if
`default_nettype wire

// *** src/bpb_slave.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpb_slave #(
   parameter logic [15:0] DEV_VECTOR = 16'h0030
) (
   // system
   input  wire logic        clk,
   input  wire logic        rst,
   // bus
   bpb_bus_if.slave         bus,
   // user side
   input  wire logic        intEnable,
   input  wire logic        intRequest,
   input  wire logic [15:0] readData,
   output logic [15:0]      addr,
   output logic [15:0]      writeData,
   output logic             writeStrobe,
   output logic             writeByte,
   output logic             refreshSeen
);
   logic [1:0]  syncS, dinS, doutS, iakS, wtS, initS, refS;
   logic [15:0] dal1, dal2;
   logic        syncD;
   logic [15:0] addrReg, addrNext, dataReg, dataNext, outReg, outNext;
   logic        oeReg, oeNext, replyReg, replyNext, irqReg, irqNext;
   logic        wsReg, wsNext, wbReg, wbNext, refReg, refNext;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         syncS <= 2'h0; dinS <= 2'h0; doutS <= 2'h0; iakS <= 2'h0;
         wtS <= 2'h0; initS <= 2'h0; refS <= 2'h0;
         dal1 <= 16'h0000; dal2 <= 16'h0000; syncD <= 1'b0;
      end else begin
         syncS <= {syncS[0], ~bus.syncN};
         dinS  <= {dinS[0], ~bus.dinN};
         doutS <= {doutS[0], ~bus.doutN};
         iakS  <= {iakS[0], ~bus.iakoN};
         wtS   <= {wtS[0], ~bus.wtbtN};
         initS <= {initS[0], ~bus.initN};
         refS  <= {refS[0], ~bus.refN};
         dal1  <= bus.dalMaster;
         dal2  <= dal1;
         syncD <= syncS[1];
      end
   end

   always_comb begin
      addrNext = addrReg; dataNext = dataReg; outNext = outReg;
      oeNext = 1'b0; replyNext = 1'b0; wsNext = 1'b0; wbNext = wbReg;
      refNext = refReg;
      irqNext = intEnable & intRequest;
      if (syncS[1] && !syncD) begin
         addrNext = dal2;
         refNext  = refS[1];
      end
      // only a requester takes the grant; reply holds until din drops
      if (dinS[1] && iakS[1] && (irqReg || replyReg)) begin
         outNext = DEV_VECTOR;
         oeNext = 1'b1; replyNext = 1'b1; irqNext = 1'b0;
      end else if (dinS[1] && syncS[1]) begin
         outNext = readData; oeNext = 1'b1; replyNext = 1'b1;
      end else if (doutS[1] && syncS[1]) begin
         replyNext = 1'b1;
         if (!replyReg) begin
            dataNext = dal2; wsNext = 1'b1; wbNext = wtS[1];
         end
      end
      // reply stays until master drops its strobe; init drops reply, request and drive
      if (initS[1]) begin
         irqNext = 1'b0; replyNext = 1'b0; oeNext = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         addrReg <= 16'h0000; dataReg <= 16'h0000; outReg <= 16'h0000;
         oeReg <= 1'b0; replyReg <= 1'b0; irqReg <= 1'b0;
         wsReg <= 1'b0; wbReg <= 1'b0; refReg <= 1'b0;
      end else begin
         addrReg <= addrNext; dataReg <= dataNext; outReg <= outNext;
         oeReg <= oeNext; replyReg <= replyNext; irqReg <= irqNext;
         wsReg <= wsNext; wbReg <= wbNext; refReg <= refNext;
      end
   end

   assign bus.dalSlave   = outReg;
   assign bus.dalSlaveOe = oeReg;
   assign bus.replyN     = ~replyReg;
   assign bus.irqN       = ~irqReg;
   assign addr           = addrReg;
   assign writeData      = dataReg;
   assign writeStrobe    = wsReg;
   assign writeByte      = wbReg;
   assign refreshSeen    = refReg;
endmodule : bpb_slave
`default_nettype wire

// *** src/bpb_master.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - power-ok drop starts power-fail trap
// - assert init while dc-ok is low
// - halt stops program, ignores interrupts, runs debug
// - refresh line activates all dynamic memories
// - each master strobe needs slave reply
// - instruction begins with fetch at program counter
// - interrupts only before fetch, priority bit clear; external event is taken in an idle cycle with priority bit clear, not halted
// - addressed slave answers input with reply
// - input reply timeout traps through location 4
// - write/byte negated in input address phase
// - read-modify-write keeps sync, output follows
// - output reply timeout traps through location 4
// - write/byte: address phase; byte whole cycle
// - priority 4 disabled, 0 enabled
// - nearest device wins interrupt priority
// - nested higher interrupts accepted at priority 0
// - device requests only with enable set
// - device supplies fixed hard-wired vector
// - external event vectors via octal 100
// - requester blocks acknowledge, replies, drives vector
// - reset instruction pulses init ten microseconds
module bpb_master #(
   parameter int REPLY_CYC = bpb_pkg::REPLY_LIMIT_CYC,
   parameter int INIT_CYC  = bpb_pkg::INIT_PULSE_CYC
) (
   // system
   input  wire logic        clk,
   input  wire logic        rst,
   // power and control pins
   input  wire logic        powerOk,
   input  wire logic        dcOk,
   input  wire logic        haltN,
   input  wire logic        eventReq,
   // bus
   bpb_bus_if.master        bus,
   // microcode side
   input  wire logic        opStart,
   input  wire bpb_pkg::bpb_cycle_type opKind,
   input  wire logic        opFetch,
   input  wire logic        opByte,
   input  wire logic        opRefresh,
   input  wire logic [15:0] opAddr,
   input  wire logic [15:0] opWdata,
   input  wire logic [15:0] pcAddr,
   input  wire logic        intsEnabled,
   input  wire logic        resetInstr,
   output logic             opBusy,
   output logic             opDone,
   output logic [15:0]      opRdata,
   output logic             trapValid,
   output logic [15:0]      trapVector,
   output logic [7:0]       statusWord,
   output logic             debugMode
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_DATA, ST_IN, ST_INEND, ST_OUT, ST_OUTEND, ST_IAK
   } bpb_state_type;

   bpb_state_type state, stateNext;
   logic [1:0]  pokS, dcS, haltS, evS, irqS, rpS;
   logic [15:0] dal1, dal2;
   logic        pokD;
   logic [31:0] tmr, tmrNext, initCnt, initCntNext;
   bpb_pkg::bpb_cycle_type kind, kindNext;
   logic        byteR, byteNext, refR, refNext, fetchR, fetchNext;
   logic [15:0] aR, aNext, wR, wNext, rdR, rdNext, vecR, vecNext;
   logic        busyR, busyNext, doneR, doneNext, trR, trNext;
   logic        syncR, syncNext, dinR, dinNext, doutR, doutNext;
   logic        wtR, wtNext, iakR, iakNext, oeR, oeNext;
   logic [15:0] dalR, dalNext;
   logic        initR, initNext;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pokS <= 2'h0; dcS <= 2'h0; haltS <= 2'h0; evS <= 2'h0;
         irqS <= 2'h0; rpS <= 2'h0; dal1 <= 16'h0000; dal2 <= 16'h0000;
         pokD <= 1'b0;
      end else begin
         pokS  <= {pokS[0], powerOk};
         dcS   <= {dcS[0], dcOk};
         haltS <= {haltS[0], ~haltN};
         evS   <= {evS[0], eventReq};
         irqS  <= {irqS[0], ~bus.irqN};
         rpS   <= {rpS[0], ~bus.replyN};
         dal1  <= bus.dalSlave;
         dal2  <= dal1;
         pokD  <= pokS[1];
      end
   end

   wire logic running = dcS[1] && !haltS[1] && !initR;
   // priority 0 allows nesting at any depth
   wire logic prioOpen = statusWord[bpb_pkg::PRIO_BIT] == 1'b0;

   always_comb begin
      stateNext = state; tmrNext = tmr; kindNext = kind;
      byteNext = byteR; refNext = refR; fetchNext = fetchR;
      aNext = aR; wNext = wR; rdNext = rdR; vecNext = vecR;
      busyNext = busyR; doneNext = 1'b0; trNext = 1'b0;
      syncNext = syncR; dinNext = dinR; doutNext = doutR;
      wtNext = wtR; iakNext = iakR; oeNext = oeR; dalNext = dalR;
      initCntNext = (initCnt != 32'd0) ? initCnt - 32'd1 : 32'd0;
      initNext = !dcS[1] || (initCnt != 32'd0);
      if (resetInstr && running) begin
         initCntNext = 32'(INIT_CYC);
      end
      if (pokD && !pokS[1] && running) begin
         trNext = 1'b1; vecNext = bpb_pkg::PWRFAIL_VEC;
      end
      case (state)
         ST_IDLE: begin
            busyNext = 1'b0;
            if (evS[1] && prioOpen && !haltS[1] && running) begin
               trNext = 1'b1; vecNext = bpb_pkg::EVENT_VEC;
            end else if (opStart && opFetch && irqS[1] && prioOpen
                         && !haltS[1] && running) begin
               busyNext = 1'b1; dinNext = 1'b1; iakNext = 1'b1;
               tmrNext = 32'd0; stateNext = ST_IAK;
               kindNext = bpb_pkg::BPB_DATI; // no output after a vector read
            end else if (opStart && !initR) begin
               busyNext = 1'b1; kindNext = opKind; byteNext = opByte;
               refNext = opRefresh; fetchNext = opFetch;
               aNext = opFetch ? pcAddr : opAddr;
               wNext = opWdata;
               dalNext = opFetch ? pcAddr : opAddr; oeNext = 1'b1;
               wtNext = (opKind == bpb_pkg::BPB_DATO) && !opFetch;
               stateNext = ST_ADDR;
            end
         end
         ST_ADDR: begin
            syncNext = 1'b1; tmrNext = 32'd0;
            // output address stands one cycle past sync so slaves latch it; input drops the drive as sync asserts
            if (kind == bpb_pkg::BPB_DATO && !fetchR) begin
               stateNext = ST_DATA;
            end else begin
               oeNext = 1'b0; dinNext = 1'b1; stateNext = ST_IN;
            end
         end
         ST_DATA: begin
            dalNext = wR; doutNext = 1'b1;
            wtNext = byteR; stateNext = ST_OUT;
         end
         ST_IN, ST_OUT, ST_IAK: begin
            tmrNext = tmr + 32'd1;
            if (rpS[1]) begin
               if (state != ST_OUT) rdNext = dal2;
               if (state == ST_IAK) begin
                  trNext = 1'b1; vecNext = dal2;
               end
               dinNext = 1'b0; doutNext = 1'b0; iakNext = 1'b0;
               stateNext = (state == ST_OUT) ? ST_OUTEND : ST_INEND;
            end else if (tmr >= 32'(REPLY_CYC) - 32'd1) begin
               trNext = 1'b1; vecNext = bpb_pkg::TIMEOUT_VEC;
               syncNext = 1'b0; dinNext = 1'b0; doutNext = 1'b0;
               iakNext = 1'b0; oeNext = 1'b0; wtNext = 1'b0;
               stateNext = ST_IDLE; busyNext = 1'b0;
            end
         end
         ST_INEND: begin
            if (!rpS[1]) begin
               if (kind == bpb_pkg::BPB_DATIO && !fetchR) begin
                  dalNext = wR; oeNext = 1'b1; doutNext = 1'b1;
                  wtNext = byteR; tmrNext = 32'd0; stateNext = ST_OUT;
               end else begin
                  syncNext = 1'b0; doneNext = 1'b1; busyNext = 1'b0;
                  stateNext = ST_IDLE;
               end
            end
         end
         ST_OUTEND: begin
            if (!rpS[1]) begin
               syncNext = 1'b0; oeNext = 1'b0; wtNext = 1'b0;
               doneNext = 1'b1; busyNext = 1'b0; stateNext = ST_IDLE;
            end
         end
         default: stateNext = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state <= ST_IDLE; tmr <= 32'd0; initCnt <= 32'd0;
         kind <= bpb_pkg::BPB_DATI; byteR <= 1'b0; refR <= 1'b0;
         fetchR <= 1'b0; aR <= 16'h0000; wR <= 16'h0000;
         rdR <= 16'h0000; vecR <= 16'h0000; busyR <= 1'b0;
         doneR <= 1'b0; trR <= 1'b0; syncR <= 1'b0; dinR <= 1'b0;
         doutR <= 1'b0; wtR <= 1'b0; iakR <= 1'b0; oeR <= 1'b0;
         dalR <= 16'h0000; initR <= 1'b1;
         statusWord <= bpb_pkg::PRIO_DISABLED; debugMode <= 1'b0;
      end else begin
         state <= stateNext; tmr <= tmrNext; initCnt <= initCntNext;
         kind <= kindNext; byteR <= byteNext; refR <= refNext;
         fetchR <= fetchNext; aR <= aNext; wR <= wNext;
         rdR <= rdNext; vecR <= vecNext; busyR <= busyNext;
         doneR <= doneNext; trR <= trNext; syncR <= syncNext;
         dinR <= dinNext; doutR <= doutNext; wtR <= wtNext;
         iakR <= iakNext; oeR <= oeNext; dalR <= dalNext;
         initR <= initNext;
         statusWord <= intsEnabled ? bpb_pkg::PRIO_ENABLED
                                   : bpb_pkg::PRIO_DISABLED;
         debugMode <= haltS[1];
      end
   end

   assign bus.dalMaster   = dalR;
   assign bus.dalMasterOe = oeR;
   assign bus.syncN       = ~syncR;
   assign bus.dinN        = ~dinR;
   assign bus.doutN       = ~doutR;
   assign bus.wtbtN       = ~wtR;
   assign bus.initN       = ~initR;
   assign bus.refN        = ~(refR && syncR);
   assign bus.iakoN       = ~iakR;
   assign opBusy          = busyR;
   assign opDone          = doneR;
   assign opRdata         = rdR;
   assign trapValid       = trR;
   assign trapVector      = vecR;
endmodule : bpb_master
`default_nettype wire

// *** sim/bpb_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module bpb_monitor #(
   parameter int REPLY_CYC = 20
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bus
   input wire logic dalSlaveOe,
   input wire logic syncN,
   input wire logic dinN,
   input wire logic doutN,
   input wire logic wtbtN,
   input wire logic replyN,
   input wire logic initN,
   input wire logic iakoN
);
   // abort needs the full wait plus a few cycles of sync pipe
   localparam int DIN_MAX = REPLY_CYC + 8;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence addrIn;
      $fell(syncN) && $past(wtbtN);
   endsequence
   sequence addrOut;
      $fell(syncN) && !$past(wtbtN);
   endsequence
   a_input_addr_phase: assert property (addrIn |-> ##[0:4] !dinN)
      else $error("input address phase without input strobe");
   a_output_addr_phase: assert property (addrOut |-> ##[0:4] !doutN)
      else $error("output address phase without output strobe");
   a_byte_wtbt_steady: assert property (
      !doutN && $past(!doutN) |-> $stable(wtbtN))
      else $error("write/byte changed during output strobe");
   a_reply_before_drop: assert property (
      $rose(dinN) || $rose(doutN) |-> !$past(replyN))
      else $error("strobe removed without reply");
   a_reply_after_strobe: assert property (
      $rose(replyN) |-> $past(dinN) && $past(doutN))
      else $error("reply dropped while strobe held");
   a_sync_ends_last: assert property (
      $rose(syncN) |-> $past(dinN) && $past(doutN) && replyN)
      else $error("sync dropped before transfer finished");
   a_din_bounded: assert property ($fell(dinN) |-> ##[1:DIN_MAX] dinN)
      else $error("input strobe held too long");
   a_init_quiet: assert property (!initN |-> syncN && doutN)
      else $error("bus cycle during init");
   a_vector_on_ack: assert property (!iakoN && !replyN |-> dalSlaveOe)
      else $error("acknowledge reply without vector");
endmodule : bpb_monitor
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam int          RC = 20;
   localparam int          IC = 20;
   localparam logic [15:0] DV = 16'h0034;
   logic        clk = 1'b0, rst = 1'b1, powerOk = 1'b0, dcOk = 1'b0;
   logic        haltN = 1'b1, eventReq = 1'b0, opStart = 1'b0, opStartM = 1'b0;
   logic        opFetch = 1'b0, opByte = 1'b0, opRefresh = 1'b0;
   logic        intsEnabled = 1'b0, resetInstr = 1'b0, intEnable = 1'b0;
   logic        intRequest = 1'b0;
   logic [15:0] opAddr = 16'h0000, opWdata = 16'h0000, pcAddr = 16'h0200;
   logic [15:0] readData = 16'h0000;
   bpb_pkg::bpb_cycle_type opKind = bpb_pkg::BPB_DATI;
   logic        opBusy, opDone, trapValid, trapValidM, debugMode, trp;
   logic        writeStrobe, writeByte, refreshSeen, lastByte;
   logic [15:0] opRdata, trapVector, trapVectorM, sAddr, writeData, lastWr;
   logic [7:0]  statusWord;
   int          mismatches = 0, checked = 0, nWr = 0, cyc = 0, n = 0;
   bpb_bus_if bus ();
   bpb_bus_if mute ();
   // silent slave: lines toggle so a stale word is never read as data
   assign mute.replyN     = 1'b1;
   assign mute.irqN       = 1'b1;
   assign mute.dalSlaveOe = 1'b0;
   assign mute.dalSlave   = {16{clk}};
   bpb_master #(.REPLY_CYC(RC), .INIT_CYC(IC)) u_bpb_master (
      .clk, .rst, .powerOk, .dcOk, .haltN, .eventReq, .bus(bus), .opStart,
      .opKind, .opFetch, .opByte, .opRefresh, .opAddr, .opWdata, .pcAddr,
      .intsEnabled, .resetInstr, .opBusy, .opDone, .opRdata, .trapValid,
      .trapVector, .statusWord, .debugMode);
   bpb_master #(.REPLY_CYC(RC), .INIT_CYC(IC)) u_bpb_master_mute (
      .clk, .rst, .powerOk, .dcOk, .haltN, .eventReq, .bus(mute),
      .opStart(opStartM), .opKind, .opFetch, .opByte, .opRefresh, .opAddr,
      .opWdata, .pcAddr, .intsEnabled, .resetInstr, .opBusy(), .opDone(),
      .opRdata(), .trapValid(trapValidM), .trapVector(trapVectorM),
      .statusWord(), .debugMode());
   bpb_slave #(.DEV_VECTOR(DV)) u_bpb_slave (
      .clk, .rst, .bus(bus), .intEnable, .intRequest, .readData,
      .addr(sAddr), .writeData, .writeStrobe, .writeByte, .refreshSeen);
   bpb_monitor #(.REPLY_CYC(RC)) u_bpb_monitor (
      .clk, .rst, .dalSlaveOe(bus.dalSlaveOe), .syncN(bus.syncN),
      .dinN(bus.dinN), .doutN(bus.doutN), .wtbtN(bus.wtbtN),
      .replyN(bus.replyN), .initN(bus.initN), .iakoN(bus.iakoN));
   initial forever #4 clk = ~clk;
   always @(posedge clk) begin
      if (writeStrobe === 1'b1) begin
         nWr      <= nWr + 1;
         lastWr   <= writeData;
         lastByte <= writeByte;
      end
   end
   task automatic check(input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t ns: seen %h, expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish
   task automatic run_op(input logic m, input bpb_pkg::bpb_cycle_type k,
                         input logic [2:0] fbr, input logic [15:0] a, d);
      @(posedge clk);
      opKind   <= k;
      {opFetch, opByte, opRefresh} <= fbr;
      opAddr   <= a;
      opWdata  <= d;
      opStart  <= !m;
      opStartM <= m;
      @(posedge clk);
      opStart  <= 1'b0;
      opStartM <= 1'b0;
      for (cyc = 1; cyc < 200; cyc++) begin
         @(posedge clk);
         #1;
         trp = m ? trapValidM : trapValid;
         if (trp === 1'b1 || (!m && opDone === 1'b1)) break;
      end
   endtask : run_op
   task automatic wait_trap(input logic [15:0] exp);
      for (int i = 0; i < 60; i++) begin
         @(posedge clk);
         #1;
         if (trapValid === 1'b1) break;
      end
      check(trapVector, exp);
   endtask : wait_trap
   initial begin
      #160000;
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      check(16'(bus.initN), 16'h0000);
      check(16'(statusWord), 16'h0080);
      @(posedge clk);
      dcOk    <= 1'b1;
      powerOk <= 1'b1;
      repeat (8) @(posedge clk);
      #1;
      check(16'(bus.initN), 16'h0001);
      $display("test reset done");
      readData <= 16'hC3A5;
      run_op(1'b0, bpb_pkg::BPB_DATI, 3'b100, 16'h1234, 16'h0000);
      check(sAddr, 16'h0200);
      check(opRdata, 16'hC3A5);
      check(16'(opBusy), 16'h0000);
      for (int i = 0; i < 3; i++) begin
         n = nWr;
         run_op(1'b0, i == 2 ? bpb_pkg::BPB_DATIO : bpb_pkg::BPB_DATO,
                {1'b0, i > 0, 1'b0}, 16'h0102, 16'h5A00 + 16'(i));
         check(lastWr, 16'h5A00 + 16'(i));
         check(16'(lastByte), 16'(i > 0));
         check(16'(nWr - n), 16'h0001);
         check(sAddr, 16'h0102);
         check(opRdata, 16'hC3A5);
      end
      for (int r = 1; r >= 0; r--) begin
         run_op(1'b0, bpb_pkg::BPB_DATI, {2'b00, r[0]}, 16'h0010, 16'h0000);
         check(16'(refreshSeen), 16'(r));
      end
      $display("test transfers done");
      for (int i = 0; i < 2; i++) begin
         run_op(1'b1, i ? bpb_pkg::BPB_DATO : bpb_pkg::BPB_DATI, 3'b000,
                16'h0400, 16'h1111);
         check(16'(trp), 16'h0001);
         check(trapVectorM, 16'h0004);
         check(16'(cyc >= RC), 16'h0001);
      end
      $display("test timeouts done");
      intEnable  <= 1'b1;
      intRequest <= 1'b1;
      run_op(1'b0, bpb_pkg::BPB_DATI, 3'b100, 16'h0000, 16'h0000);
      check(16'(trp), 16'h0000);
      intsEnabled <= 1'b1;
      run_op(1'b0, bpb_pkg::BPB_DATI, 3'b000, 16'h0000, 16'h0000);
      check(16'(trp), 16'h0000);
      check(16'(statusWord), 16'h0000);
      run_op(1'b0, bpb_pkg::BPB_DATI, 3'b100, 16'h0000, 16'h0000);
      check(16'(trp), 16'h0001);
      check(trapVector, DV);
      intEnable <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check(16'(bus.irqN), 16'h0001);
      $display("test interrupts done");
      @(posedge clk);
      eventReq <= 1'b1;
      wait_trap(16'h0040);
      @(posedge clk);
      eventReq <= 1'b0;
      repeat (10) @(posedge clk);
      powerOk <= 1'b0;
      wait_trap(16'h0014);
      @(posedge clk);
      powerOk <= 1'b1;
      haltN   <= 1'b0;
      repeat (6) @(posedge clk);
      #1;
      check(16'(debugMode), 16'h0001);
      @(posedge clk);
      haltN <= 1'b1;
      repeat (6) @(posedge clk);
      resetInstr <= 1'b1;
      @(posedge clk);
      resetInstr <= 1'b0;
      n = 0;
      repeat (3 * IC) begin
         @(posedge clk);
         #1;
         if (bus.initN === 1'b0) n++;
      end
      check(16'(n >= IC - 1 && n <= IC + 1), 16'h0001);
      $display("test events done");
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
